/* hw/timer2_reload_capture.sv */
// Functional notes
// R1: count built from low and high bytes
// R2: split clear gives one 16-bit reload counter
// R3: system_clock, system_clock/12, rtc/8 or comparator clocks
// R4: 16-bit wrap reloads and sets high flag
// R5: interrupt on each 16-bit overflow when enabled
// R6: low byte wrap interrupts if low enable
// R7: split gives two 8-bit reload counters
// R8: run gates high half; low always runs
// R9: per-half system_clock select else external code
// R10: split sets each half's overflow flag
// R11: split interrupts on high, or either
// R12: flags cleared only by software write
// R13: software reads both flags to find source
// R14: capture mode entered by capture enable bit
// R15: software keeps 16-bit mode while capturing
// R16: capture on comparator rise or rtc/8
// R17: capture copies count to reload, sets flag
// R18: software clocks fast, differences captures
// R19: reserved clock code gives no count clock
// R20: set high flag vectors when interrupt enabled
//
// Our own choices: the address map and strobed register access.
`include "timer2_params.svh"
`timescale 1ns/100ps
`default_nettype none
module timer2_reload_capture (
  input wire logic mclk,
  input wire logic nrst,
  timer2_link_if.device link,
  input wire logic rtcClk,
  input wire logic cmpOut,
  output logic highOverflow,
  output logic lowOverflow
);
  import timer2_pkg::*;

  // ==================================================
  // registers
  byte_type ctrl_r;
  byte_type clockCtrl_r;
  byte_type reloadLow_r;
  byte_type reloadHigh_r;
  word_type count_r;
  byte_type rdata_r;
  logic [3:0] prescale_r;
  logic [2:0] rtcDiv_r;
  logic rtcMeta_r;
  logic rtcSync_r;
  logic rtcPrev_r;
  logic cmpMeta_r;
  logic cmpSync_r;
  logic cmpPrev_r;

  // ==================================================
  // decoded control
  logic highFlag;
  logic lowFlag;
  logic lowIrqEn;
  logic captureEn;
  logic splitMode;
  logic highRun;
  xclk_type extSel;
  logic sysTick;
  logic sysDivTick;
  logic rtcRise;
  logic rtcTick;
  logic cmpRise;
  logic lowTick;
  logic highTick;
  logic captureEvt;
  logic wideStep;
  logic wideWrap;
  logic lowStep;
  logic lowWrap;
  logic highStep;
  logic highWrap;
  logic highSet;
  logic lowSet;
  logic wrCtrl;
  logic wrCount;

  assign highFlag = ctrl_r[`CTRL_HIGH_FLAG_BIT];
  assign lowFlag = ctrl_r[`CTRL_LOW_FLAG_BIT];
  assign lowIrqEn = ctrl_r[`CTRL_LOW_IRQ_EN_BIT];
  assign captureEn = ctrl_r[`CTRL_CAPTURE_EN_BIT];
  assign splitMode = ctrl_r[`CTRL_SPLIT_BIT];
  assign highRun = ctrl_r[`CTRL_RUN_BIT];
  assign extSel = ctrl_r[`CTRL_XCLK_HI_BIT:`CTRL_XCLK_LO_BIT];

  // picks a half's count enable from its select bit and the shared code
  function automatic logic pickTick(
    input logic useSys,
    input xclk_type code,
    input logic sysT,
    input logic divT,
    input logic rtcT,
    input logic cmpT
  );
    logic t;
    t = 1'b0;
    if (useSys) begin
      t = sysT;
    end else if (code == `XCLK_SYS_DIV) begin
      t = divT;
    end else if (code == `XCLK_RTC_DIV) begin
      t = rtcT;
    end else if (code == `XCLK_CMP) begin
      t = cmpT;
    end else begin
      t = 1'b0; // R19
    end
    return t;
  endfunction

  // ==================================================
  // pin synchronisers; the first stage feeds no logic, the second and third feed the edge detect
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rtcMeta_r <= 1'b0;
      rtcSync_r <= 1'b0;
      rtcPrev_r <= 1'b0;
    end else begin
      rtcMeta_r <= rtcClk; // R3
      rtcSync_r <= rtcMeta_r;
      rtcPrev_r <= rtcSync_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cmpMeta_r <= 1'b0;
      cmpSync_r <= 1'b0;
      cmpPrev_r <= 1'b0;
    end else begin
      cmpMeta_r <= cmpOut; // R3
      cmpSync_r <= cmpMeta_r;
      cmpPrev_r <= cmpSync_r;
    end
  end

  assign rtcRise = rtcSync_r & ~rtcPrev_r;
  assign cmpRise = cmpSync_r & ~cmpPrev_r;

  // ==================================================
  // clock dividers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prescale_r <= 4'h0;
    end else if (sysDivTick) begin
      prescale_r <= 4'h0;
    end else begin
      prescale_r <= prescale_r + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rtcDiv_r <= 3'h0;
    end else if (rtcRise) begin
      rtcDiv_r <= rtcDiv_r + 3'h1;
    end
  end

  assign sysTick = 1'b1;
  assign sysDivTick = (prescale_r == 4'(`SYS_PRESCALE - 1)); // R3
  assign rtcTick = rtcRise && (rtcDiv_r == 3'(`RTC_PRESCALE - 1)); // R3
  assign lowTick = pickTick(clockCtrl_r[`CLOCK_CTRL_REG_LOW_SYS_BIT], extSel, sysTick, sysDivTick,
                            rtcTick, cmpRise); // R9
  assign highTick = pickTick(clockCtrl_r[`CLOCK_CTRL_REG_HIGH_SYS_BIT], extSel, sysTick, sysDivTick,
                             rtcTick, cmpRise); // R9

  // ==================================================
  // count events
  assign wideStep = !splitMode && highRun && lowTick; // R2
  assign wideWrap = wideStep && (count_r == 16'hffff); // R4
  assign lowStep = splitMode && lowTick; // R8
  assign lowWrap = (lowStep || wideStep) && (count_r[7:0] == 8'hff); // R6 R10
  assign highStep = splitMode && highRun && highTick; // R8
  assign highWrap = highStep && (count_r[15:8] == 8'hff); // R10
  assign captureEvt = captureEn && (extSel[1] ? cmpRise : rtcTick); // R14 R16
  assign highSet = wideWrap || highWrap || captureEvt; // R4 R10 R17
  assign lowSet = lowWrap;
  assign wrCtrl = link.sfrWr && (link.sfrAddr == `T2_CTRL_ADDR);
  assign wrCount = link.sfrWr && ((link.sfrAddr == `T2_COUNT_LOW_ADDR) ||
                                  (link.sfrAddr == `T2_COUNT_HIGH_ADDR));

  // ==================================================
  // control register; a hardware set beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_r <= `CTRL_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= link.sfrWdata;
      end
      if (highSet || (wrCtrl && link.sfrWdata[`CTRL_HIGH_FLAG_BIT])) begin
        ctrl_r[`CTRL_HIGH_FLAG_BIT] <= 1'b1; // R12
      end else if (wrCtrl) begin
        ctrl_r[`CTRL_HIGH_FLAG_BIT] <= 1'b0;
      end
      if (lowSet || (wrCtrl && link.sfrWdata[`CTRL_LOW_FLAG_BIT])) begin
        ctrl_r[`CTRL_LOW_FLAG_BIT] <= 1'b1; // R12
      end else if (wrCtrl) begin
        ctrl_r[`CTRL_LOW_FLAG_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clockCtrl_r <= `BYTE_RESET;
    end else if (link.sfrWr && (link.sfrAddr == `T2_CLOCK_CTRL_ADDR)) begin
      clockCtrl_r <= link.sfrWdata; // R9
    end
  end

  // ==================================================
  // reload pair; a capture outranks a software write
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reloadLow_r <= `BYTE_RESET;
      reloadHigh_r <= `BYTE_RESET;
    end else if (captureEvt) begin
      reloadLow_r <= count_r[7:0]; // R17
      reloadHigh_r <= count_r[15:8]; // R17
    end else if (link.sfrWr && (link.sfrAddr == `T2_RELOAD_LOW_ADDR)) begin
      reloadLow_r <= link.sfrWdata;
    end else if (link.sfrWr && (link.sfrAddr == `T2_RELOAD_HIGH_ADDR)) begin
      reloadHigh_r <= link.sfrWdata;
    end
  end

  // ==================================================
  // counter; a software byte write stalls counting that cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count_r <= 16'h0000;
    end else if (wrCount) begin
      if (link.sfrAddr == `T2_COUNT_LOW_ADDR) begin
        count_r[7:0] <= link.sfrWdata; // R1
      end else begin
        count_r[15:8] <= link.sfrWdata; // R1
      end
    end else if (wideStep) begin
      if (wideWrap) begin
        count_r <= {reloadHigh_r, reloadLow_r}; // R4
      end else begin
        count_r <= count_r + 16'h0001; // R2
      end
    end else begin
      if (lowStep) begin
        count_r[7:0] <= lowWrap ? reloadLow_r : count_r[7:0] + 8'h01; // R7
      end
      if (highStep) begin
        count_r[15:8] <= highWrap ? reloadHigh_r : count_r[15:8] + 8'h01; // R7
      end
    end
  end

  // ==================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r <= `BYTE_RESET;
    end else if (link.sfrRd) begin
      if (link.sfrAddr == `T2_CTRL_ADDR) begin
        rdata_r <= ctrl_r; // R13
      end else if (link.sfrAddr == `T2_RELOAD_LOW_ADDR) begin
        rdata_r <= reloadLow_r;
      end else if (link.sfrAddr == `T2_RELOAD_HIGH_ADDR) begin
        rdata_r <= reloadHigh_r;
      end else if (link.sfrAddr == `T2_COUNT_LOW_ADDR) begin
        rdata_r <= count_r[7:0];
      end else if (link.sfrAddr == `T2_COUNT_HIGH_ADDR) begin
        rdata_r <= count_r[15:8];
      end else if (link.sfrAddr == `T2_CLOCK_CTRL_ADDR) begin
        rdata_r <= clockCtrl_r;
      end else begin
        rdata_r <= `BYTE_RESET;
      end
    end
  end

  // ==================================================
  // interrupt request; a level held by the flags
  assign link.sfrRdata = rdata_r;
  assign link.irqReq = link.timerIrqEn && (highFlag || (lowIrqEn && lowFlag)); // R5 R6 R11 R20
  assign highOverflow = highFlag;
  assign lowOverflow = lowFlag;

endmodule
`default_nettype wire

/* hw/timer2_params.svh */
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

// ==================================================
// device register addresses
`define T2_CTRL_ADDR 8'hc8
`define T2_RELOAD_LOW_ADDR 8'hca
`define T2_RELOAD_HIGH_ADDR 8'hcb
`define T2_COUNT_LOW_ADDR 8'hcc
`define T2_COUNT_HIGH_ADDR 8'hcd
`define T2_CLOCK_CTRL_ADDR 8'h8e

// ==================================================
// host register addresses
`define HOST_IE_ADDR 8'ha8
`define HOST_VECTOR_ADDR 8'hf0

// ==================================================
// control register fields
`define CTRL_HIGH_FLAG_BIT 7
`define CTRL_LOW_FLAG_BIT 6
`define CTRL_LOW_IRQ_EN_BIT 5
`define CTRL_CAPTURE_EN_BIT 4
`define CTRL_SPLIT_BIT 3
`define CTRL_RUN_BIT 2
`define CTRL_XCLK_HI_BIT 1
`define CTRL_XCLK_LO_BIT 0
`define CLOCK_CTRL_REG_HIGH_SYS_BIT 1
`define CLOCK_CTRL_REG_LOW_SYS_BIT 0
`define IE_TIMER_BIT 5

// ==================================================
// reset values and external clock codes
`define CTRL_RESET 8'h00
`define BYTE_RESET 8'h00
`define XCLK_SYS_DIV 2'h0
`define XCLK_RTC_DIV 2'h1
`define XCLK_RESERVED 2'h2
`define XCLK_CMP 2'h3

// ==================================================
// clock division counts
`define SYS_PRESCALE 12
`define RTC_PRESCALE 8

`endif

/* hw/timer2_pkg.sv */
package timer2_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [15:0] word_type;
  typedef logic [1:0] xclk_type;
endpackage

/* hw/timer2_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface timer2_link_if (
  input wire logic mclk
);
  import timer2_pkg::*;
  byte_type sfrAddr;
  byte_type sfrWdata;
  logic sfrWr;
  logic sfrRd;
  byte_type sfrRdata;
  logic timerIrqEn;
  logic irqReq;

  modport device (
    input sfrAddr, sfrWdata, sfrWr, sfrRd, timerIrqEn,
    output sfrRdata, irqReq
  );
  modport host (
    output sfrAddr, sfrWdata, sfrWr, sfrRd, timerIrqEn,
    input sfrRdata, irqReq
  );
endinterface
`default_nettype wire

/* hw/timer2_core_side.sv */
`include "timer2_params.svh"
`timescale 1ns/100ps
`default_nettype none
module timer2_core_side (
  input wire logic mclk,
  input wire logic nrst,
  timer2_link_if.host link,
  input wire timer2_pkg::byte_type addr,
  input wire timer2_pkg::byte_type wdata,
  input wire logic wr,
  input wire logic rd,
  output timer2_pkg::byte_type rdata,
  output logic vectorPulse
);
  import timer2_pkg::*;

  // ==================================================
  // own registers
  byte_type intEnable_r;
  byte_type vectorCount_r;
  byte_type localData_r;
  logic localSel_r;
  logic irqPrev_r;
  logic isLocal;

  assign isLocal = (addr == `HOST_IE_ADDR) || (addr == `HOST_VECTOR_ADDR);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      intEnable_r <= `BYTE_RESET;
    end else if (wr && (addr == `HOST_IE_ADDR)) begin
      intEnable_r <= wdata; // R5
    end
  end

  // counts vectors taken; a new one needs the request to drop first
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irqPrev_r <= 1'b0;
      vectorCount_r <= `BYTE_RESET;
    end else begin
      irqPrev_r <= link.irqReq;
      if (vectorPulse) begin
        vectorCount_r <= vectorCount_r + 8'h01; // R20
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      localSel_r <= 1'b0;
      localData_r <= `BYTE_RESET;
    end else if (rd) begin
      localSel_r <= isLocal;
      localData_r <= (addr == `HOST_IE_ADDR) ? intEnable_r : vectorCount_r;
    end
  end

  // ==================================================
  // all other addresses go straight to the timer
  assign link.sfrAddr = addr;
  assign link.sfrWdata = wdata;
  assign link.sfrWr = wr && !isLocal; // R12
  assign link.sfrRd = rd && !isLocal; // R13
  assign link.timerIrqEn = intEnable_r[`IE_TIMER_BIT]; // R5
  assign vectorPulse = link.irqReq && !irqPrev_r; // R20
  assign rdata = localSel_r ? localData_r : link.sfrRdata;

endmodule
`default_nettype wire

/* sim/timer2_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module timer2_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire timer2_pkg::byte_type sfrAddr,
  input wire timer2_pkg::byte_type sfrWdata,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire timer2_pkg::byte_type sfrRdata,
  input wire logic timerIrqEn,
  input wire logic irqReq
);
  import timer2_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // ==========
  // bus traffic
  one_strobe_a: assert property (!(sfrWr && sfrRd))
    else $error("both strobes high");
  host_local_a: assert property ((sfrWr || sfrRd) |-> sfrAddr != 8'ha8 && sfrAddr != 8'hf0)
    else $error("host address forwarded");
  unmapped_zero_a: assert property (sfrRd && sfrAddr == 8'h50 |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (sfrRd && sfrAddr == 8'hc8 && $past(sfrWr, 2) &&
    $past(sfrAddr, 2) == 8'hc8 |=> (sfrRdata & 8'h3f) == ($past(sfrWdata, 3) & 8'h3f))
    else $error("control bits lost");
  clock_ctrl_reg_readback_a: assert property (sfrRd && sfrAddr == 8'h8e && $past(sfrWr, 2) &&
    $past(sfrAddr, 2) == 8'h8e |=> (sfrRdata & 8'h03) == ($past(sfrWdata, 3) & 8'h03))
    else $error("clock select lost");
  // ==========
  // interrupt request
  irq_gate_a: assert property (!timerIrqEn |-> !irqReq)
    else $error("request while disabled");
  irq_hold_a: assert property ($fell(irqReq) |-> $fell(timerIrqEn) ||
    $past(sfrWr) && $past(sfrAddr) == 8'hc8)
    else $error("flag cleared by itself");
  irq_flags_a: assert property (sfrRd && sfrAddr == 8'hc8 && irqReq |=>
    sfrRdata[7] || sfrRdata[6] && sfrRdata[5])
    else $error("request without flag");
  quiet_flags_a: assert property (sfrRd && sfrAddr == 8'hc8 && timerIrqEn && !irqReq |=>
    !sfrRdata[7])
    else $error("high flag without request");
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import timer2_pkg::*;
  logic mclk, vecP, hiOv, loOv;
  logic nrst = 1'h0, wr = 1'h0, rd = 1'h0, rdD = 1'h0, rtcClk = 1'h0, cmpOut = 1'h0;
  byte_type addr = 8'h00, wdata = 8'h00, rdata, rl, rh;
  byte_type regs[7] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h8e, 8'hf0};
  logic [15:0] q[$];
  logic [15:0] e;
  int miscompares, num_checks, cyc, vecN;
  timer2_link_if lnk (.mclk(mclk));
  timer2_reload_capture i_timer2_reload_capture (.mclk(mclk), .nrst(nrst), .link(lnk),
    .rtcClk(rtcClk), .cmpOut(cmpOut), .highOverflow(hiOv), .lowOverflow(loOv));
  timer2_core_side i_timer2_core_side (.mclk(mclk), .nrst(nrst), .link(lnk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vectorPulse(vecP));
  timer2_checker chk (.mclk(mclk), .nrst(nrst), .sfrAddr(lnk.sfrAddr),
    .sfrWdata(lnk.sfrWdata), .sfrWr(lnk.sfrWr), .sfrRd(lnk.sfrRd),
    .sfrRdata(lnk.sfrRdata), .timerIrqEn(lnk.timerIrqEn), .irqReq(lnk.irqReq));
  // ==========
  // tasks
  task automatic check(input byte_type s, input byte_type x);
    num_checks++;
    if (s !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wrb(input byte_type a, input byte_type d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask
  // expectation is queued before the strobe so the monitor never runs dry
  task automatic rdb(input byte_type a, input byte_type x, input byte_type m);
    q.push_back({m, x & m});
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
  endtask
  // ==========
  // clock, rtc pin, timeout, monitor
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // rtc runs free at a tenth of mclk, so rtc/8 ticks every 80 cycles
  always @(posedge mclk) begin
    rdD <= rd;
    cyc <= cyc + 1;
    // counts vector pulses as the core side sees them
    if (vecP === 1'h1) vecN <= vecN + 1;
    if (cyc % 5 == 0) rtcClk <= ~rtcClk;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // read data stand from the cycle after the strobe until the next read
  always @(negedge mclk) begin
    if (rdD === 1'h1) begin
      e = q.pop_front();
      check(rdata & e[15:8], e[7:0]);
    end
  end
  // ==========
  // scenarios
  initial begin
    void'($urandom(32'h2ae6));
    rl = 8'($urandom()) & 8'h3f;
    rh = 8'($urandom()) & 8'h7f;
    idle(16);
    nrst <= 1'h1;
    foreach (regs[i]) rdb(regs[i], 8'h00, 8'hff);
    wrb(8'h50, rh);
    rdb(8'h50, 8'h00, 8'hff);
    wrb(8'hca, rl);
    wrb(8'hcb, rh);
    rdb(8'hca, rl, 8'hff);
    rdb(8'hcb, rh, 8'hff);
    wrb(8'h8e, 8'h03);
    rdb(8'h8e, 8'h03, 8'h03);
    wrb(8'ha8, 8'h20);
    wrb(8'hcd, 8'hff);
    wrb(8'hcc, 8'hf0);
    wrb(8'hc8, 8'h04);
    idle(40);
    rdb(8'hc8, 8'h84, 8'hbf);
    check({6'h0, loOv, hiOv}, 8'h03);
    rdb(8'hcd, rh, 8'hff);
    rdb(8'hf0, 8'h01, 8'hff);
    check(8'(vecN), 8'h01);
    idle(300);
    rdb(8'hc8, 8'h84, 8'hbf);
    wrb(8'hc8, 8'h24);
    idle(300);
    rdb(8'hc8, 8'h64, 8'hff);
    rdb(8'hf0, 8'h02, 8'hff);
    wrb(8'hc8, 8'h28);
    wrb(8'hcd, 8'h55);
    wrb(8'hcc, 8'hf8);
    idle(20);
    rdb(8'hcd, 8'h55, 8'hff);
    rdb(8'hc8, 8'h68, 8'hff);
    rdb(8'hf0, 8'h03, 8'hff);
    check(8'(vecN), 8'h03);
    check({6'h0, loOv, hiOv}, 8'h02);
    wrb(8'hc8, 8'h2c);
    idle(200);
    rdb(8'hc8, 8'hac, 8'hbf);
    wrb(8'h8e, 8'h01);
    wrb(8'hc8, 8'h2e);
    wrb(8'hcd, 8'h99);
    idle(30);
    rdb(8'hcd, 8'h99, 8'hff);
    wrb(8'hc8, 8'h2c);
    wrb(8'hcd, 8'h00);
    idle(60);
    // 61 counting edges at /12 give five or six ticks, never zero
    rdb(8'hcd, 8'h04, 8'hfc);
    wrb(8'hc8, 8'h2d);
    wrb(8'hcd, 8'h00);
    idle(180);
    // 181 counting edges at rtc/8 give two or three ticks
    rdb(8'hcd, 8'h02, 8'hfe);
    wrb(8'hc8, 8'h2f);
    wrb(8'hcd, 8'h00);
    repeat (2) begin
      cmpOut <= 1'h1;
      idle(5);
      cmpOut <= 1'h0;
      idle(5);
    end
    rdb(8'hcd, 8'h02, 8'hff);
    wrb(8'hc8, 8'h17);
    rdb(8'hc8, 8'h17, 8'h3f);
    wrb(8'hcc, 8'h00);
    wrb(8'hcd, 8'h12);
    idle(5);
    cmpOut <= 1'h1;
    idle(10);
    cmpOut <= 1'h0;
    rdb(8'hcb, 8'h12, 8'hff);
    rdb(8'hc8, 8'h97, 8'hff);
    wrb(8'hc8, 8'h15);
    wrb(8'hcc, 8'h00);
    wrb(8'hcd, 8'h34);
    idle(120);
    rdb(8'hcb, 8'h34, 8'hff);
    nrst <= 1'h0;
    idle(3);
    nrst <= 1'h1;
    rdb(8'hc8, 8'h00, 8'hff);
    idle(3);
    stop_test();
  end
endmodule
`default_nettype wire
